// *** design/cipc_pkg.sv ***
// Package for the core identity and exception pend control block.
// Holds register offsets, field positions, reset values, states and carrier structs.
// Assumes a single core clock and a plain strobe register port.
package cipc_pkg;

  // Register port widths
  localparam int unsigned CIPC_ADDR_W = 8;
  localparam int unsigned CIPC_DATA_W = 32;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] CIPC_OFS_IDENTITY   = 8'h00;
  localparam logic [7:0] CIPC_OFS_PEND_CTRL  = 8'h04;
  localparam logic [7:0] CIPC_OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] CIPC_OFS_IRQ_CLEAR  = 8'h0C;
  localparam logic [7:0] CIPC_OFS_IRQ_ENABLE = 8'h10;

  // Identity word field positions
  localparam int unsigned CIPC_ID_IMPL_LSB  = 24;
  localparam int unsigned CIPC_ID_VAR_LSB   = 20;
  localparam int unsigned CIPC_ID_ARCH_LSB  = 16;
  localparam int unsigned CIPC_ID_PART_LSB  = 4;
  localparam int unsigned CIPC_ID_PATCH_LSB = 0;

  // Pend control word bit positions
  localparam int unsigned CIPC_NMI_SET_BIT = 31;
  localparam int unsigned CIPC_RSVD_HI_BIT = 30;
  localparam int unsigned CIPC_RSVD_LO_BIT = 29;
  localparam int unsigned CIPC_SV_SET_BIT  = 28;
  localparam int unsigned CIPC_SV_CLR_BIT  = 27;

  // Event status bits
  localparam int unsigned CIPC_EVT_NUM       = 4;
  localparam int unsigned CIPC_EVT_NMI_SET   = 0;
  localparam int unsigned CIPC_EVT_NMI_ENTRY = 1;
  localparam int unsigned CIPC_EVT_SV_SET    = 2;
  localparam int unsigned CIPC_EVT_SV_CLEAR  = 3;

  // Values after reset
  localparam logic [31:0] CIPC_RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  CIPC_RST_EVT  = 4'h0;
  localparam logic [0:0]  CIPC_RST_BIT  = 1'h0;

  // Non-maskable pending and handler tracking
  typedef enum logic [1:0] {
    CIPC_NMI_IDLE    = 2'b00,
    CIPC_NMI_PENDING = 2'b01,
    CIPC_NMI_HANDLER = 2'b10,
    CIPC_NMI_REPEND  = 2'b11
  } cipc_nmi_state_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cipc_bus_req_t;

  // Exception entry logic events toward this block
  typedef struct packed {
    logic nmi_assert;
    logic nmi_entry;
    logic nmi_return;
    logic sv_entry;
  } cipc_core_evt_t;

endpackage

// *** design/cipc_sticky_bit.sv ***
// Sticky status bits for the event register.
// Assumes set and clear are one-cycle pulses on the core clock.
`timescale 1ns/1ps
module cipc_sticky_bit #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] q
);
  import cipc_pkg::*;

  // One flag per bit; a set in the clearing cycle wins so no event is lost
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          q[i] <= 1'b0;
        end else if (set[i]) begin
          q[i] <= 1'b1;
        end else if (clr[i]) begin
          q[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// *** design/cipc_top.sv ***
// Core identity word and exception pend control register block.
// Assumes a plain strobe register port and one-cycle event pulses from the core's exception logic.
//
// Function
// [RL1] Identity word is read-only; top byte implementer, bits 19:16 fixed constant.
// [RL2] Identity bits 23:20 report the major variant number.
// [RL3] Identity bits 15:4 report the fixed twelve-bit part number.
// [RL4] Identity bits 3:0 report the patch number.
// [RL5] Writing one to pend bit 31 makes the non-maskable interrupt pending.
// [RL6] Reading pend bit 31 returns the non-maskable pending state.
// [RL7] Handler entry clears the non-maskable pending bit.
// [RL8] Inside the handler the bit reads one only after a fresh assertion.
// [RL9] Pend bits 30 and 29 read zero and ignore writes.
// [RL10] Writing one to pend bit 28 makes the deferred service pending.
// [RL11] Reading pend bit 28 returns the deferred service pending state.
// [RL12] Only a software write of one sets deferred service pending.
// [RL13] Pend bit 27 is write-only; writing one removes deferred service pending.
`timescale 1ns/1ps
module cipc_top #(
  parameter logic [7:0]  IMPL_CODE  = 8'h5A,   // Arbitrary value
  parameter logic [3:0]  VARIANT    = 4'h2,    // Arbitrary value
  parameter logic [3:0]  ARCH_CONST = 4'hA,    // Arbitrary value
  parameter logic [11:0] PART_CODE  = 12'h3B5, // Arbitrary value
  parameter logic [3:0]  PATCH      = 4'h3     // Arbitrary value
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire cipc_pkg::cipc_bus_req_t bus_req,
  output logic [31:0]                  bus_rdata,
  input  wire cipc_pkg::cipc_core_evt_t core_evt,
  output logic                         nmi_pending,
  output logic                         nmi_in_handler,
  output logic                         sv_pending,
  output logic                         irq
);
  import cipc_pkg::*;

  // Decoded write strobes
  logic                     wr_pend;
  logic                     wr_irq_clear;
  logic                     wr_irq_enable;
  logic                     sw_nmi_set;
  logic                     sw_sv_set;
  logic                     sw_sv_clr;
  logic                     nmi_set_any;
  logic                     addr_hit;

  // State
  cipc_nmi_state_t          nmi_state_reg;
  cipc_nmi_state_t          nmi_state_next;
  logic                     sv_pending_reg;
  logic [CIPC_EVT_NUM-1:0]  evt_status;
  logic [CIPC_EVT_NUM-1:0]  evt_set;
  logic [CIPC_EVT_NUM-1:0]  evt_clr;
  logic [CIPC_EVT_NUM-1:0]  irq_enable_reg;
  logic [31:0]              rdata_reg;
  logic [31:0]              rdata_next;
  logic [31:0]              identity_word;
  logic [31:0]              pend_word;
  logic                     irq_reg;

  // Write decode; strobes are never both high so no read/write arbitration
  assign wr_pend       = bus_req.wr && (bus_req.addr == CIPC_OFS_PEND_CTRL);
  assign wr_irq_clear  = bus_req.wr && (bus_req.addr == CIPC_OFS_IRQ_CLEAR);
  assign wr_irq_enable = bus_req.wr && (bus_req.addr == CIPC_OFS_IRQ_ENABLE);

  // [RL5] Non-maskable set
  assign sw_nmi_set = wr_pend && bus_req.wdata[CIPC_NMI_SET_BIT];
  // [RL10] Deferred service set
  assign sw_sv_set  = wr_pend && bus_req.wdata[CIPC_SV_SET_BIT];
  // [RL13] Deferred service clear
  assign sw_sv_clr  = wr_pend && bus_req.wdata[CIPC_SV_CLR_BIT];

  // A pin assertion pends the non-maskable interrupt just like the software bit
  assign nmi_set_any = sw_nmi_set || core_evt.nmi_assert;

  // Identity word is built from constants only, so nothing can ever alter it
  // [RL1] Implementer byte
  assign identity_word[31:CIPC_ID_IMPL_LSB]               = IMPL_CODE;
  // [RL2] Major variant number
  assign identity_word[CIPC_ID_IMPL_LSB-1:CIPC_ID_VAR_LSB] = VARIANT;
  // [RL1] Fixed architecture constant
  assign identity_word[CIPC_ID_VAR_LSB-1:CIPC_ID_ARCH_LSB] = ARCH_CONST;
  // [RL3] Fixed part number
  assign identity_word[CIPC_ID_ARCH_LSB-1:CIPC_ID_PART_LSB] = PART_CODE;
  // [RL4] Patch number
  assign identity_word[CIPC_ID_PART_LSB-1:CIPC_ID_PATCH_LSB] = PATCH;

  // Next non-maskable state; a new assertion always wins over entry or return
  always_comb begin
    nmi_state_next = nmi_state_reg;
    unique case (nmi_state_reg)
      CIPC_NMI_IDLE: begin
        if (nmi_set_any) begin
          nmi_state_next = CIPC_NMI_PENDING;
        end
      end
      CIPC_NMI_PENDING: begin
        // [RL7] Entry clears pending
        if (core_evt.nmi_entry) begin
          nmi_state_next = nmi_set_any ? CIPC_NMI_REPEND : CIPC_NMI_HANDLER;
        end
      end
      CIPC_NMI_HANDLER: begin
        // [RL8] Reassertion in handler
        if (nmi_set_any) begin
          nmi_state_next = core_evt.nmi_return ? CIPC_NMI_PENDING : CIPC_NMI_REPEND;
        end else if (core_evt.nmi_return) begin
          nmi_state_next = CIPC_NMI_IDLE;
        end
      end
      CIPC_NMI_REPEND: begin
        // Pending survives the return, so the handler is taken again
        if (core_evt.nmi_return) begin
          nmi_state_next = CIPC_NMI_PENDING;
        end
      end
    endcase
  end

  // Non-maskable state register
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_state_reg <= CIPC_NMI_IDLE;
    end else begin
      nmi_state_reg <= nmi_state_next;
    end
  end

  // Deferred service pending; set wins if set and clear land together
  always_ff @(posedge clk) begin
    if (rst) begin
      sv_pending_reg <= CIPC_RST_BIT[0];
    end else if (sw_sv_set) begin
      // [RL12] Software is the only set
      sv_pending_reg <= 1'b1;
    end else if (sw_sv_clr || core_evt.sv_entry) begin
      // [RL13] Clear removes pending
      sv_pending_reg <= 1'b0;
    end
  end

  // Event sources for the interrupt status register
  assign evt_set[CIPC_EVT_NMI_SET]   = nmi_set_any;
  assign evt_set[CIPC_EVT_NMI_ENTRY] = core_evt.nmi_entry && (nmi_state_reg == CIPC_NMI_PENDING);
  assign evt_set[CIPC_EVT_SV_SET]    = sw_sv_set;
  assign evt_set[CIPC_EVT_SV_CLEAR]  = sw_sv_clr && sv_pending_reg && !sw_sv_set;
  assign evt_clr = wr_irq_clear ? bus_req.wdata[CIPC_EVT_NUM-1:0] : CIPC_RST_EVT;

  // Sticky status flags, write-one-to-clear through the clear register
  cipc_sticky_bit #(
    .WIDTH (CIPC_EVT_NUM)
  ) u_status (
    .clk (clk),
    .rst (rst),
    .set (evt_set),
    .clr (evt_clr),
    .q   (evt_status)
  );

  // Interrupt enable register
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enable_reg <= CIPC_RST_EVT;
    end else if (wr_irq_enable) begin
      irq_enable_reg <= bus_req.wdata[CIPC_EVT_NUM-1:0];
    end
  end

  // Interrupt level registered to keep the output glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_status & irq_enable_reg);
    end
  end

  // Readable view of the pend control word
  always_comb begin
    pend_word = CIPC_RST_WORD;
    // [RL6] Non-maskable pending readback
    pend_word[CIPC_NMI_SET_BIT] = (nmi_state_reg == CIPC_NMI_PENDING) ||
                                  (nmi_state_reg == CIPC_NMI_REPEND);
    // [RL9] Reserved read zero
    pend_word[CIPC_RSVD_HI_BIT] = 1'b0;
    pend_word[CIPC_RSVD_LO_BIT] = 1'b0;
    // [RL11] Deferred service readback
    pend_word[CIPC_SV_SET_BIT]  = sv_pending_reg;
    // Clear bit is write-only and always reads zero
    pend_word[CIPC_SV_CLR_BIT]  = 1'b0;
  end

  // Read mux; unmapped and write-only addresses read zero
  always_comb begin
    rdata_next = CIPC_RST_WORD;
    addr_hit   = 1'b1;
    unique case (bus_req.addr)
      CIPC_OFS_IDENTITY:   rdata_next = identity_word;
      CIPC_OFS_PEND_CTRL:  rdata_next = pend_word;
      CIPC_OFS_IRQ_STATUS: rdata_next[CIPC_EVT_NUM-1:0] = evt_status;
      CIPC_OFS_IRQ_ENABLE: rdata_next[CIPC_EVT_NUM-1:0] = irq_enable_reg;
      default:             addr_hit = 1'b0;
    endcase
    if (!bus_req.rd || !addr_hit) begin
      rdata_next = CIPC_RST_WORD;
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= CIPC_RST_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs
  assign bus_rdata      = rdata_reg;
  assign nmi_pending    = pend_word[CIPC_NMI_SET_BIT];
  assign nmi_in_handler = (nmi_state_reg == CIPC_NMI_HANDLER) || (nmi_state_reg == CIPC_NMI_REPEND);
  assign sv_pending     = sv_pending_reg;
  assign irq            = irq_reg;

endmodule

// *** test/cipc_top_props.sv ***
// Checker for the identity word and pend control block.
// Assumes it is bound to cipc_top and sees only that module's ports.
`timescale 1ns/1ps
module cipc_top_props
  import cipc_pkg::*;
#(
  parameter logic [7:0]  IMPL_CODE  = 8'h5A,
  parameter logic [3:0]  VARIANT    = 4'h2,
  parameter logic [3:0]  ARCH_CONST = 4'hA,
  parameter logic [11:0] PART_CODE  = 12'h3B5,
  parameter logic [3:0]  PATCH      = 4'h3
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire cipc_pkg::cipc_bus_req_t  bus_req,
  input wire logic [31:0]              bus_rdata,
  input wire cipc_pkg::cipc_core_evt_t core_evt,
  input wire logic                     nmi_pending,
  input wire logic                     nmi_in_handler,
  input wire logic                     sv_pending,
  input wire logic                     irq
);
  logic pend_wr;
  logic nmi_set;
  logic sv_set;
  // Pend word writes decoded once; a pin assertion pends like software
  assign pend_wr = bus_req.wr && bus_req.addr == CIPC_OFS_PEND_CTRL;
  assign nmi_set = (pend_wr && bus_req.wdata[31]) || core_evt.nmi_assert;
  assign sv_set  = pend_wr && bus_req.wdata[28];

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_nmi_sw_set: assert property (pend_wr && bus_req.wdata[31] |=> nmi_pending)
    else $error("nmi set write lost");
  a_nmi_pend_hold: assert property (nmi_pending && !core_evt.nmi_entry |=> nmi_pending)
    else $error("nmi pending dropped without entry");
  a_nmi_entry_clr: assert property (nmi_pending && core_evt.nmi_entry && !nmi_set |=>
    !nmi_pending && nmi_in_handler)
    else $error("handler entry did not clear nmi pending");
  a_nmi_handler_quiet: assert property (nmi_in_handler && !nmi_pending && !nmi_set |=> !nmi_pending)
    else $error("nmi pending rose in handler without reassert");
  a_sv_sw_set: assert property (sv_set |=> sv_pending)
    else $error("deferred service set lost");
  a_sv_only_sw: assert property (!sv_pending && !sv_set |=> !sv_pending)
    else $error("deferred service pended without software");
  a_sv_sw_clr: assert property (sv_pending && pend_wr && bus_req.wdata[27] && !sv_set |=> !sv_pending)
    else $error("deferred service clear ignored");
  a_pend_read: assert property (bus_req.rd && bus_req.addr == CIPC_OFS_PEND_CTRL |=>
    bus_rdata == {$past(nmi_pending), 2'b00, $past(sv_pending), 28'h000_0000})
    else $error("pend word readback wrong");
  a_id_read: assert property (bus_req.rd && bus_req.addr == CIPC_OFS_IDENTITY |=>
    bus_rdata == {IMPL_CODE, VARIANT, ARCH_CONST, PART_CODE, PATCH})
    else $error("identity word wrong");
endmodule

bind cipc_top cipc_top_props #(.IMPL_CODE(IMPL_CODE), .VARIANT(VARIANT), .ARCH_CONST(ARCH_CONST),
  .PART_CODE(PART_CODE), .PATCH(PATCH)) u_props (.clk(clk), .rst(rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .core_evt(core_evt), .nmi_pending(nmi_pending),
  .nmi_in_handler(nmi_in_handler), .sv_pending(sv_pending), .irq(irq));

// *** test/testbench.sv ***
// Self-checking bench for the identity word and pend control block.
// Assumes default identity parameters and fixed one-cycle read latency.
`timescale 1ns/1ps
module testbench;
  import cipc_pkg::*;
  localparam logic [31:0] ID_WORD = 32'h5A2A_3B53;
  logic           clk;
  logic           rst;
  cipc_bus_req_t  bus_req;
  logic [31:0]    bus_rdata;
  cipc_core_evt_t core_evt;
  logic           nmi_pending;
  logic           nmi_in_handler;
  logic           sv_pending;
  logic           irq;
  int             failures;
  int             compares;

  cipc_top uut (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .core_evt(core_evt),
    .nmi_pending(nmi_pending), .nmi_in_handler(nmi_in_handler), .sv_pending(sv_pending), .irq(irq));

  // Free-running core clock, 50 ns period
  always #25 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle strobes; a gap cycle follows so no strobe is driven twice per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    // Return mid-cycle so outputs launched by the write are settled when compared
    @(negedge clk);
  endtask

  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    chk(bus_rdata, e);
  endtask

  task automatic ev(input logic [3:0] e);
    @(posedge clk);
    core_evt <= e;
    @(posedge clk);
    core_evt <= 4'h0;
    // Return mid-cycle so the state after the event is settled when compared
    @(negedge clk);
  endtask

  task automatic finish_test();
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    bus_req = '0;
    core_evt = '0;
    failures = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Identity fields, and writes to the identity word are dropped
    rd(CIPC_OFS_IDENTITY, ID_WORD);
    wr(CIPC_OFS_IDENTITY, 32'h0000_0000);
    rd(CIPC_OFS_IDENTITY, ID_WORD);
    wr(CIPC_OFS_PEND_CTRL, 32'h6000_0000);
    rd(CIPC_OFS_PEND_CTRL, 32'h0000_0000);
    wr(CIPC_OFS_IRQ_ENABLE, 32'h0000_000F);
    // Non-maskable pend, handler entry, reassert inside the handler
    wr(CIPC_OFS_PEND_CTRL, 32'h8000_0000);
    rd(CIPC_OFS_PEND_CTRL, 32'h8000_0000);
    chk(32'(irq), 32'h0000_0001);
    ev(4'h4);
    rd(CIPC_OFS_PEND_CTRL, 32'h0000_0000);
    chk(32'(nmi_in_handler), 32'h0000_0001);
    ev(4'h8);
    rd(CIPC_OFS_PEND_CTRL, 32'h8000_0000);
    ev(4'h2);
    rd(CIPC_OFS_PEND_CTRL, 32'h8000_0000);
    ev(4'h4);
    ev(4'h2);
    rd(CIPC_OFS_PEND_CTRL, 32'h0000_0000);
    rd(CIPC_OFS_IRQ_STATUS, 32'h0000_0003);
    wr(CIPC_OFS_IRQ_CLEAR, 32'h0000_000F);
    rd(CIPC_OFS_IRQ_STATUS, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    // Deferred service set, clear, set-wins and handler entry
    wr(CIPC_OFS_PEND_CTRL, 32'h1000_0000);
    rd(CIPC_OFS_PEND_CTRL, 32'h1000_0000);
    wr(CIPC_OFS_PEND_CTRL, 32'h0800_0000);
    rd(CIPC_OFS_PEND_CTRL, 32'h0000_0000);
    rd(CIPC_OFS_IRQ_STATUS, 32'h0000_000C);
    wr(CIPC_OFS_PEND_CTRL, 32'h1800_0000);
    chk(32'(sv_pending), 32'h0000_0001);
    ev(4'h1);
    chk(32'(sv_pending), 32'h0000_0000);
    // Core events never pend the deferred service; the pin pends the non-maskable one
    ev(4'hE);
    rd(CIPC_OFS_PEND_CTRL, 32'h8000_0000);
    // Entry beside a fresh assertion leaves it pending inside the handler
    ev(4'hC);
    rd(CIPC_OFS_PEND_CTRL, 32'h8000_0000);
    chk(32'(nmi_in_handler), 32'h0000_0001);
    ev(4'h2);
    ev(4'h4);
    ev(4'h2);
    rd(CIPC_OFS_PEND_CTRL, 32'h0000_0000);
    // Masked status leaves irq low until enabled, then clear drops it
    wr(CIPC_OFS_IRQ_CLEAR, 32'h0000_000F);
    wr(CIPC_OFS_IRQ_ENABLE, 32'h0000_0000);
    wr(CIPC_OFS_PEND_CTRL, 32'h1000_0000);
    rd(CIPC_OFS_IRQ_STATUS, 32'h0000_0004);
    chk(32'(irq), 32'h0000_0000);
    wr(CIPC_OFS_IRQ_ENABLE, 32'h0000_0004);
    rd(CIPC_OFS_IRQ_ENABLE, 32'h0000_0004);
    chk(32'(irq), 32'h0000_0001);
    wr(CIPC_OFS_IRQ_CLEAR, 32'h0000_0004);
    rd(CIPC_OFS_IRQ_CLEAR, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    // Unmapped place reads zero and swallows writes
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    rd(CIPC_OFS_PEND_CTRL, 32'h1000_0000);
    finish_test();
  end
endmodule
